/* File: fcs_pkg.sv */
// package: constants, commands, status layout and operation codes of the flash host
package fcs_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int WE_PULSE_NS = 50;
	localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_NS = 80;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_CYC = 2;
	localparam int RD_PULSE_CYC = ACCESS_CYC + SYNC_CYC;
	localparam int RECOVER_NS = 25;
	localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RP_LOW_NS = 100;
	localparam int RP_LOW_CYC = (RP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;

	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_IDENTIFY = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
	localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
	localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
	localparam logic [15:0] NULL_WORD = 16'hFFFF;
	localparam logic [15:0] NULL_BYTE = 16'h00FF;

	// ----------------------------------------
	// operation_status layout
	// ----------------------------------------
	localparam int ST_READY_BIT = 7;
	localparam int ST_SUSPEND_BIT = 6;
	localparam int ST_ERASE_ERR_BIT = 5;
	localparam int ST_PROG_ERR_BIT = 4;
	localparam int ST_SUPPLY_BIT = 3;

	// ----------------------------------------
	// user operations
	// ----------------------------------------
	typedef enum logic [2:0] {
		FCS_OP_COMMAND,
		FCS_OP_READ,
		FCS_OP_PROGRAM,
		FCS_OP_ERASE,
		FCS_OP_CANCEL,
		FCS_OP_POLL,
		FCS_OP_RESET
	} fcs_op_t;

endpackage : fcs_pkg

/* File: fcs_cycle.sv */
// module: one asynchronous bus cycle (write or read) on the flash pins
module fcs_cycle #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic write,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	output logic done,
	output logic [DATA_W-1:0] rdata,
	output logic [ADDR_W-1:0] flash_addr,
	output logic ce_b,
	output logic we_b,
	output logic oe_b,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [DATA_W-1:0] dq_in
);
	import fcs_pkg::*;

	typedef enum logic [2:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD, CY_RECOVER} fcs_cy_t;

	fcs_cy_t st, next_st;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic write_q, next_write_q;
	logic next_done, next_ce_b, next_we_b, next_oe_b, next_dq_oe;
	logic [DATA_W-1:0] next_rdata, next_dq_out;
	logic [ADDR_W-1:0] next_flash_addr;
	logic [DATA_W-1:0] dq_meta, dq_sync;

	// ----------------------------------------
	// data input synchroniser
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dq_meta <= '0;
			dq_sync <= '0;
		end else begin
			dq_meta <= dq_in;
			dq_sync <= dq_meta;
		end
	end

	// ----------------------------------------
	// cycle sequencer
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_write_q = write_q;
		next_done = 1'b0;
		next_rdata = rdata;
		next_flash_addr = flash_addr;
		next_ce_b = ce_b;
		next_we_b = 1'b1;
		next_oe_b = 1'b1;
		next_dq_out = dq_out;
		next_dq_oe = dq_oe;
		unique case (st)
			CY_IDLE: begin
				if (start) begin
					next_st = CY_SETUP;
					next_write_q = write;
					next_flash_addr = addr;
					next_dq_out = wdata;
					next_dq_oe = write;
					next_ce_b = 1'b0;
				end
			end
			CY_SETUP: begin
				next_st = CY_PULSE;
				next_cnt = '0;
				next_we_b = !write_q;
				next_oe_b = write_q;
			end
			CY_PULSE: begin
				next_cnt = cnt + 1'b1;
				next_we_b = !write_q;
				next_oe_b = write_q;
				if (write_q && cnt == CNT_W'(WE_PULSE_CYC - 1)) begin
					next_st = CY_HOLD;
					next_we_b = 1'b1;
				end else if (!write_q && cnt == CNT_W'(RD_PULSE_CYC - 1)) begin
					next_st = CY_HOLD;
					next_oe_b = 1'b1;
					next_rdata = dq_sync;
				end
			end
			CY_HOLD: begin
				next_st = CY_RECOVER;
				next_cnt = '0;
				next_ce_b = 1'b1;
			end
			CY_RECOVER: begin
				next_cnt = cnt + 1'b1;
				next_dq_oe = 1'b0;
				if (cnt == CNT_W'(RECOVER_CYC - 1)) begin
					next_st = CY_IDLE;
					next_done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= CY_IDLE;
			cnt <= '0;
			write_q <= 1'b0;
			done <= 1'b0;
			rdata <= '0;
			flash_addr <= '0;
			ce_b <= 1'b1;
			we_b <= 1'b1;
			oe_b <= 1'b1;
			dq_out <= '0;
			dq_oe <= 1'b0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			write_q <= next_write_q;
			done <= next_done;
			rdata <= next_rdata;
			flash_addr <= next_flash_addr;
			ce_b <= next_ce_b;
			we_b <= next_we_b;
			oe_b <= next_oe_b;
			dq_out <= next_dq_out;
			dq_oe <= next_dq_oe;
		end
	end

endmodule : fcs_cycle

/* File: fcs_host.sv */
// module: host controller that sequences flash commands over the parallel pins
module fcs_host #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire fcs_pkg::fcs_op_t cmd_op,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [DATA_W-1:0] cmd_data,
	input wire logic cmd_boot,
	input wire logic byte_mode,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_data,
	output logic rsp_error,
	output logic [ADDR_W-1:0] flash_addr,
	output logic flash_ce_b,
	output logic flash_we_b,
	output logic flash_oe_b,
	output logic flash_byte_b,
	output logic reset_powerdown_pin_b,
	output logic flash_wp,
	output logic [DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [DATA_W-1:0] flash_dq_in
);
	import fcs_pkg::*;

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (DATA_W != 16) begin : g_bad_data
		$error("fcs_host needs DATA_W of 16");
	end
	if (ADDR_W < 18) begin : g_bad_addr
		$error("fcs_host needs ADDR_W of at least 18");
	end

	typedef enum logic [2:0] {S_IDLE, S_FIRST, S_SECOND, S_POLL, S_RESET} fcs_st_t;

	fcs_st_t st, next_st;
	fcs_op_t op_q, next_op_q;
	logic [ADDR_W-1:0] addr_q, next_addr_q;
	logic [DATA_W-1:0] data_q, next_data_q;
	logic boot_q, next_boot_q;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic eng_start, next_eng_start;
	logic eng_write, next_eng_write;
	logic [DATA_W-1:0] eng_wdata, next_eng_wdata;
	logic eng_done;
	logic [DATA_W-1:0] eng_rdata;
	logic next_cmd_ready, next_rsp_valid, next_rsp_error;
	logic [DATA_W-1:0] next_rsp_data;
	logic next_byte_b, next_rp_b, next_wp;

	// ----------------------------------------
	// bus cycle engine
	// ----------------------------------------
	fcs_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
		.clk(clk),
		.rst_b(rst_b),
		.start(eng_start),
		.write(eng_write),
		.addr(addr_q),
		.wdata(eng_wdata),
		.done(eng_done),
		.rdata(eng_rdata),
		.flash_addr(flash_addr),
		.ce_b(flash_ce_b),
		.we_b(flash_we_b),
		.oe_b(flash_oe_b),
		.dq_out(flash_dq_out),
		.dq_oe(flash_dq_oe),
		.dq_in(flash_dq_in)
	);

	// ----------------------------------------
	// operation sequencer
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_op_q = op_q;
		next_addr_q = addr_q;
		next_data_q = data_q;
		next_boot_q = boot_q;
		next_cnt = cnt;
		next_eng_start = 1'b0;
		next_eng_write = eng_write;
		next_eng_wdata = eng_wdata;
		next_cmd_ready = cmd_ready;
		next_rsp_valid = 1'b0;
		next_rsp_data = rsp_data;
		next_rsp_error = rsp_error;
		next_byte_b = flash_byte_b;
		next_rp_b = 1'b1;
		next_wp = 1'b0;
		unique case (st)
			S_IDLE: begin
				next_byte_b = !byte_mode;
				if (cmd_valid && cmd_ready) begin
					next_op_q = cmd_op;
					next_addr_q = cmd_addr;
					next_data_q = cmd_data;
					next_boot_q = cmd_boot;
					next_cmd_ready = 1'b0;
					next_eng_start = 1'b1;
					next_eng_write = 1'b1;
					next_st = S_FIRST;
					unique case (cmd_op)
						FCS_OP_COMMAND: next_eng_wdata = {8'h00, cmd_data[7:0]};
						FCS_OP_READ: next_eng_write = 1'b0;
						FCS_OP_PROGRAM: next_eng_wdata = {8'h00, CMD_PROGRAM_SETUP};
						FCS_OP_CANCEL: next_eng_wdata = {8'h00, CMD_PROGRAM_SETUP};
						FCS_OP_ERASE: next_eng_wdata = {8'h00, CMD_ERASE_SETUP};
						FCS_OP_POLL: begin
							next_eng_write = 1'b0;
							next_st = S_POLL;
						end
						FCS_OP_RESET: begin
							next_eng_start = 1'b0;
							next_rp_b = 1'b0;
							next_cnt = '0;
							next_st = S_RESET;
						end
					endcase
				end
			end
			S_FIRST: begin
				if (eng_done) begin
					if (op_q == FCS_OP_COMMAND || op_q == FCS_OP_READ) begin
						next_st = S_IDLE;
						next_cmd_ready = 1'b1;
						next_rsp_valid = 1'b1;
						next_rsp_data = op_q == FCS_OP_READ ? eng_rdata : data_q;
						next_rsp_error = 1'b0;
					end else begin
						next_st = S_SECOND;
						next_eng_start = 1'b1;
						next_eng_write = 1'b1;
						next_wp = boot_q;
						if (op_q == FCS_OP_PROGRAM) begin
							next_eng_wdata = data_q;
						end else if (op_q == FCS_OP_ERASE) begin
							next_eng_wdata = {8'h00, CMD_ERASE_CONFIRM};
						end else begin
							next_eng_wdata = flash_byte_b ? NULL_WORD : NULL_BYTE;
						end
					end
				end
			end
			S_SECOND: begin
				next_wp = boot_q;
				if (eng_done) begin
					next_wp = 1'b0;
					if (op_q == FCS_OP_CANCEL) begin
						next_st = S_IDLE;
						next_cmd_ready = 1'b1;
						next_rsp_valid = 1'b1;
						next_rsp_data = '0;
						next_rsp_error = 1'b0;
					end else begin
						next_st = S_POLL;
						next_eng_start = 1'b1;
						next_eng_write = 1'b0;
					end
				end
			end
			S_POLL: begin
				if (eng_done) begin
					if (eng_rdata[ST_READY_BIT]) begin
						next_st = S_IDLE;
						next_cmd_ready = 1'b1;
						next_rsp_valid = 1'b1;
						next_rsp_data = {8'h00, eng_rdata[7:3], 3'b000};
						next_rsp_error = |eng_rdata[ST_ERASE_ERR_BIT:ST_SUPPLY_BIT];
					end else begin
						next_eng_start = 1'b1;
						next_eng_write = 1'b0;
					end
				end
			end
			S_RESET: begin
				next_cnt = cnt + 1'b1;
				next_rp_b = 1'b0;
				if (cnt == CNT_W'(RP_LOW_CYC - 1)) begin
					next_rp_b = 1'b1;
					next_st = S_IDLE;
					next_cmd_ready = 1'b1;
					next_rsp_valid = 1'b1;
					next_rsp_data = '0;
					next_rsp_error = 1'b0;
				end
			end
			default: begin
				next_st = S_IDLE;
				next_cmd_ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= S_IDLE;
			op_q <= FCS_OP_COMMAND;
			addr_q <= '0;
			data_q <= '0;
			boot_q <= 1'b0;
			cnt <= '0;
			eng_start <= 1'b0;
			eng_write <= 1'b0;
			eng_wdata <= '0;
			cmd_ready <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			rsp_error <= 1'b0;
			flash_byte_b <= 1'b1;
			reset_powerdown_pin_b <= 1'b1;
			flash_wp <= 1'b0;
		end else begin
			st <= next_st;
			op_q <= next_op_q;
			addr_q <= next_addr_q;
			data_q <= next_data_q;
			boot_q <= next_boot_q;
			cnt <= next_cnt;
			eng_start <= next_eng_start;
			eng_write <= next_eng_write;
			eng_wdata <= next_eng_wdata;
			cmd_ready <= next_cmd_ready;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
			rsp_error <= next_rsp_error;
			flash_byte_b <= next_byte_b;
			reset_powerdown_pin_b <= next_rp_b;
			flash_wp <= next_wp;
		end
	end

endmodule : fcs_host

/* File: fcs_host_monitor.sv */
// checker: pin and handshake relations of the flash host
module fcs_host_monitor #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire fcs_pkg::fcs_op_t cmd_op,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [DATA_W-1:0] rsp_data,
	input wire logic rsp_error,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic flash_ce_b,
	input wire logic flash_we_b,
	input wire logic flash_oe_b,
	input wire logic reset_powerdown_pin_b,
	input wire logic flash_dq_oe
);
	import fcs_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence s_take(fcs_op_t op);
		cmd_valid && cmd_ready && cmd_op == op;
	endsequence
	sequence s_write;
		##2 !flash_ce_b ##1 !flash_we_b [*2] ##1 flash_we_b && !flash_ce_b
		##1 flash_ce_b ##2 rsp_valid;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
		else $error("ready stayed high after accept");
	a_rsp_one: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid)
		else $error("bad response pulse");
	a_cmd_walk: assert property (s_take(FCS_OP_COMMAND) |-> s_write)
		else $error("command write walk wrong");
	a_write_pins: assert property (!flash_we_b |-> !flash_ce_b && flash_oe_b && flash_dq_oe)
		else $error("write strobe without ce or with oe");
	a_read_pins: assert property (!flash_oe_b |-> flash_we_b && !flash_ce_b && !flash_dq_oe)
		else $error("read strobe conflict");
	a_oe_toggle: assert property ($fell(flash_oe_b) |=> !flash_oe_b [*5] ##1 flash_oe_b)
		else $error("read strobe length wrong");
	a_addr_held: assert property (!flash_ce_b && !$past(flash_ce_b) |-> $stable(flash_addr))
		else $error("address moved in cycle");
	a_rp_pulse: assert property (s_take(FCS_OP_RESET) |=> !reset_powerdown_pin_b [*4]
		##1 reset_powerdown_pin_b && rsp_valid)
		else $error("reset pulse wrong");
	a_err_flags: assert property (rsp_valid && rsp_error |-> (|rsp_data[5:3])
		&& rsp_data[2:0] == 3'h0)
		else $error("error flag without status bits");
endmodule : fcs_host_monitor

bind fcs_host fcs_host_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) fcs_host_monitor_inst (
	.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
	.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
	.rsp_error(rsp_error), .flash_addr(flash_addr), .flash_ce_b(flash_ce_b),
	.flash_we_b(flash_we_b), .flash_oe_b(flash_oe_b),
	.reset_powerdown_pin_b(reset_powerdown_pin_b), .flash_dq_oe(flash_dq_oe));

/* File: fcs_flash_model.sv */
// model: behavioural flash device behind the host pins
module fcs_flash_model #(
	parameter int BUSY_CYC = 40,
	parameter logic [15:0] MFR_CODE = 16'h005A, // arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h00C3 // arbitrary value
) (
	input wire logic clk,
	input wire logic rp_b,
	input wire logic ce_b,
	input wire logic we_b,
	input wire logic oe_b,
	input wire logic byte_b,
	input wire logic wp,
	input wire logic [17:0] addr,
	input wire logic [15:0] dq,
	output logic [15:0] dq_in,
	input wire logic vpp_ok,
	input wire logic prog_fail,
	input wire logic erase_fail
);
	logic [15:0] mem [int];
	logic [2:0] err = 3'h0;
	logic [1:0] mode = 2'h0;
	logic [1:0] pend = 2'h0;
	logic susp = 1'b0;
	logic we_q = 1'b1;
	logic oe_q = 1'b1;
	logic is_prog = 1'b0;
	logic [17:0] pa;
	logic [15:0] pd;
	logic [15:0] q = 16'h0000;
	int busy = 0;
	wire [7:0] st = {busy == 0 || susp, susp, err, 3'h0};
	assign dq_in = q;
	function automatic logic [15:0] arr(input logic [17:0] a);
		return mem.exists(a) ? mem[a] : {a[7:0], ~a[7:0]};
	endfunction : arr
	always @(posedge clk or negedge rp_b) begin
		if (!rp_b) begin
			err = 3'h0;
			susp = 1'b0;
			busy = 0;
			mode = 2'h0;
			pend = 2'h0;
		end else begin
			if (busy > 0 && !susp) begin
				busy--;
				if (busy == 0 && is_prog && prog_fail) err[1] = 1'b1;
				else if (busy == 0 && is_prog) mem[pa] = arr(pa) & pd;
				else if (busy == 0 && erase_fail) err[2] = 1'b1;
			end
			if (we_b && !we_q && !ce_b && oe_b) begin
				if (busy > 0 && !susp) begin
					if (!is_prog && dq[7:0] == 8'hB0) susp = 1'b1;
				end else if (pend == 2'h1) begin
					pend = 2'h0;
					mode = 2'h2;
					if (!(dq == 16'hFFFF || (!byte_b && dq[7:0] == 8'hFF))) begin
						if (!vpp_ok) err[0] = 1'b1;
						if (addr[17:12] == 6'h00 && !wp) err[1] = 1'b1;
						else if (!err[0]) begin
							busy = BUSY_CYC;
							is_prog = 1'b1;
							pa = addr;
							pd = dq;
						end
					end
				end else if (pend == 2'h2) begin
					pend = 2'h0;
					mode = 2'h2;
					if (dq[7:0] == 8'hD0) begin
						if (!vpp_ok) err[0] = 1'b1;
						if (!err[0]) busy = BUSY_CYC;
						is_prog = 1'b0;
					end else err[2:1] = 2'h3;
				end else if (susp) begin
					if (dq[7:0] == 8'hD0) susp = 1'b0;
					if (dq[7:0] == 8'hFF) mode = 2'h0;
				end else begin
					case (dq[7:0])
						8'hFF: mode = 2'h0;
						8'h90: mode = 2'h1;
						8'h70: mode = 2'h2;
						8'h50: err = 3'h0;
						8'h40, 8'h10: pend = 2'h1;
						8'h20: pend = 2'h2;
						default: ;
					endcase
					if (pend != 2'h0) mode = 2'h2;
				end
			end
			if (!oe_b && oe_q && !ce_b) begin
				q <= (busy > 0 && !susp || mode == 2'h2) ? {8'h00, st}
					: mode == 2'h1 ? (addr[0] ? DEV_CODE : MFR_CODE) : arr(addr);
			end else if (oe_b || ce_b) q <= ~q;
			we_q = we_b;
			oe_q = oe_b;
		end
	end
endmodule : fcs_flash_model

/* File: fcs_host_bench.sv */
// testbench: flash host against the flash model
module fcs_host_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import fcs_pkg::*;
	logic clk, rst_b, cmd_valid, cmd_boot, byte_mode, cmd_ready, rsp_valid, rsp_error;
	fcs_op_t cmd_op;
	logic [17:0] cmd_addr, flash_addr;
	logic [15:0] cmd_data, rsp_data, dq_out, dq_in;
	logic ce_b, we_b, oe_b, byte_b, rp_b, wp, dq_oe, vpp_ok, prog_fail, erase_fail;
	int miscompares = 0;
	int samples_checked = 0;
	fcs_host fcs_host_inst (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_boot(cmd_boot),
		.byte_mode(byte_mode), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_error(rsp_error), .flash_addr(flash_addr),
		.flash_ce_b(ce_b), .flash_we_b(we_b), .flash_oe_b(oe_b), .flash_byte_b(byte_b),
		.reset_powerdown_pin_b(rp_b), .flash_wp(wp), .flash_dq_out(dq_out),
		.flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
	fcs_flash_model fcs_flash_model_inst (.clk(clk), .rp_b(rp_b), .ce_b(ce_b), .we_b(we_b),
		.oe_b(oe_b), .byte_b(byte_b), .wp(wp), .addr(flash_addr), .dq(dq_out), .dq_in(dq_in),
		.vpp_ok(vpp_ok), .prog_fail(prog_fail), .erase_fail(erase_fail));
	always #12.5 clk = ~clk;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out
	task automatic run(input fcs_op_t op, input logic [17:0] a, input logic [15:0] d,
		input logic b);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 99) begin
			@(negedge clk);
			n++;
		end
		if (n >= 99) begin
			miscompares++;
			close_out();
		end
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		cmd_boot = b;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 3000) begin
			miscompares++;
			close_out();
		end
		@(negedge clk);
	endtask : run
	task automatic wr(input logic [7:0] c);
		run(FCS_OP_COMMAND, 18'h00000, {8'h00, c}, 1'b0);
	endtask : wr
	task automatic rd(input logic [17:0] a);
		run(FCS_OP_READ, a, 16'h0000, 1'b0);
	endtask : rd
	task automatic chk_w(input string nm, input logic [15:0] e);
		samples_checked++;
		if (rsp_data !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, rsp_data);
		end
	endtask : chk_w
	task automatic chk_b(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask : chk_b
	function automatic logic [15:0] dflt(input logic [17:0] a);
		return {a[7:0], ~a[7:0]};
	endfunction : dflt
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{clk, rst_b, cmd_valid, cmd_boot, byte_mode, prog_fail, erase_fail} = 7'h00;
		cmd_op = FCS_OP_READ;
		cmd_addr = 18'h00000;
		cmd_data = 16'h0000;
		vpp_ok = 1'b1;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		rd(18'h01234); chk_w("array", dflt(18'h01234));
		wr(8'h90); chk_w("echo", 16'h0090);
		rd(18'h00000); chk_w("maker", 16'h005A);
		rd(18'h00001); chk_w("device", 16'h00C3);
		wr(8'h70); rd(18'h00003); chk_w("status", 16'h0080);
		$display("modes done");
		run(FCS_OP_PROGRAM, 18'h05010, 16'h0F0F, 0); chk_w("prog", 16'h0080);
		chk_b("prog err", 1'b0, rsp_error);
		rd(18'h00002); chk_w("status mode", 16'h0080);
		wr(8'hFF); rd(18'h05010); chk_w("written", dflt(18'h05010) & 16'h0F0F);
		byte_mode = 1'b1;
		repeat (3) @(negedge clk);
		chk_b("byte pin", 1'b0, byte_b);
		run(FCS_OP_CANCEL, 18'h05020, 16'h0000, 0);
		rd(18'h0); chk_w("null", 16'h0080);
		byte_mode = 1'b0;
		wr(8'hFF); rd(18'h05020); chk_w("kept word", dflt(18'h05020));
		$display("program done");
		prog_fail = 1'b1;
		run(FCS_OP_PROGRAM, 18'h05030, 16'h0000, 0); chk_w("wfail", 16'h0090);
		chk_b("wfail err", 1'b1, rsp_error);
		prog_fail = 1'b0;
		wr(8'h70); rd(18'h0); chk_w("persist", 16'h0090);
		wr(8'h50); rd(18'h0); chk_w("cleared", 16'h0080);
		erase_fail = 1'b1;
		run(FCS_OP_ERASE, 18'h20000, 16'h0000, 0); chk_w("efail", 16'h00A0);
		erase_fail = 1'b0;
		wr(8'h50);
		vpp_ok = 1'b0;
		run(FCS_OP_ERASE, 18'h20000, 16'h0000, 0); chk_w("supply", 16'h0088);
		vpp_ok = 1'b1;
		run(FCS_OP_PROGRAM, 18'h05040, 16'h0000, 0); chk_w("refuse", 16'h0088);
		wr(8'hFF); rd(18'h05040); chk_w("refused", dflt(18'h05040));
		wr(8'h50);
		run(FCS_OP_PROGRAM, 18'h00100, 16'h0000, 0); chk_w("boot lock", 16'h0090);
		wr(8'h50);
		run(FCS_OP_PROGRAM, 18'h00100, 16'h0000, 1); chk_w("boot ok", 16'h0080);
		wr(8'hFF); rd(18'h00100); chk_w("boot word", 16'h0000);
		$display("errors done");
		wr(8'h20); wr(8'hD0); wr(8'hB0); rd(18'h0); chk_w("suspend", 16'h00C0);
		wr(8'hD0); run(FCS_OP_POLL, 18'h0, 16'h0, 0); chk_w("resumed", 16'h0080);
		prog_fail = 1'b1;
		run(FCS_OP_PROGRAM, 18'h05050, 16'h0000, 0);
		prog_fail = 1'b0;
		wr(8'h10); run(FCS_OP_COMMAND, 18'h05060, 16'h0000, 0);
		wr(8'hFF); rd(18'h0); chk_w("busy", 16'h0010);
		run(FCS_OP_RESET, 18'h0, 16'h0, 0);
		rd(18'h05060); chk_w("rst", dflt(18'h05060));
		wr(8'h70); rd(18'h0); chk_w("rst status", 16'h0080);
		$display("suspend and reset done");
		close_out();
	end
endmodule : fcs_host_bench
